//--- logic/pam_port_a_mux.sv
// Function multiplexer for the 32 shared lines of the first I/O port.
`timescale 1ns/1ps
`default_nettype none
`include "pam_consts.svh"
module pam_port_a_mux #(
  parameter logic [31:0] RESET_PERIPH_MASK = `PAM_RESET_PERIPH
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              cfg_we,
  input  wire pam_pkg::pam_cfg_t cfg,
  input  wire logic [31:0]       gpio_out,
  input  wire logic [31:0]       gpio_oe,
  input  wire logic [31:0]       periph_a_out,
  input  wire logic [31:0]       periph_a_oe,
  input  wire logic [31:0]       periph_b_out,
  input  wire logic [31:0]       periph_b_oe,
  input  wire logic [31:0]       pad_in,
  output logic [31:0]            pad_out,
  output logic [31:0]            pad_oe_n,
  output logic [31:0]            pad_pullup,
  output logic [31:0]            gpio_in,
  output logic [31:0]            periph_a_in,
  output logic [31:0]            periph_b_in,
  output logic [31:0]            peripheral_select_status,
  output pam_pkg::pam_avail_t    avail
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when some line of the mask is handed to the chosen function.
  function automatic logic f_used(input logic [31:0] mask,
                                  input logic [31:0] pio_en,
                                  input logic [31:0] b_sel,
                                  input logic        want_b);
    logic [31:0] hit;
    hit = mask & ~pio_en & (want_b ? b_sel : ~b_sel);
    return |hit;
  endfunction : f_used

  ////////////////////////////////////////////////////////////////////////////
  // Selection state.

  logic [31:0] pio_en_q;
  logic [31:0] pio_en_d;
  logic [31:0] b_sel_q;
  logic [31:0] b_sel_d;
  logic [31:0] pu_dis_q;
  logic [31:0] pu_dis_d;

  always_comb begin
    pio_en_d = pio_en_q;
    b_sel_d  = b_sel_q;
    pu_dis_d = pu_dis_q;
    if (cfg_we) begin
      pio_en_d = cfg.pio_en;
      b_sel_d  = cfg.b_sel;
      pu_dis_d = cfg.pu_dis;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pio_en_q <= ~RESET_PERIPH_MASK;
      b_sel_q  <= `PAM_ALL_ZERO;
      pu_dis_q <= `PAM_ALL_ZERO;
    end else begin
      pio_en_q <= pio_en_d;
      b_sel_q  <= b_sel_d;
      pu_dis_q <= pu_dis_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feature use and exclusions.

  logic fast_irq_used;
  logic wait_used;
  logic nand_used;
  logic card_used;
  logic spi_used;
  logic irq_zero_used;
  logic irq_one_used;
  logic clk_low_used;
  logic clk_two_used;
  logic clk_three_used;
  logic upper_b_used;
  logic wide_bus;

  always_comb begin
    fast_irq_used  = f_used(`PAM_M_FAST_IRQ, pio_en_q, b_sel_q, 1'h0);
    wait_used      = f_used(`PAM_M_EXT_WAIT, pio_en_q, b_sel_q, 1'h0);
    nand_used      = f_used(`PAM_M_NAND, pio_en_q, b_sel_q, 1'h0);
    card_used      = f_used(`PAM_M_FLASH_CARD, pio_en_q, b_sel_q, 1'h0);
    spi_used       = f_used(`PAM_M_SPI, pio_en_q, b_sel_q, 1'h1);
    irq_zero_used  = f_used(`PAM_M_IRQ_ZERO, pio_en_q, b_sel_q, 1'h0);
    irq_one_used   = f_used(`PAM_M_IRQ_ONE, pio_en_q, b_sel_q, 1'h0);
    clk_low_used   = f_used(`PAM_M_CLK_LOW, pio_en_q, b_sel_q, 1'h1);
    clk_two_used   = f_used(`PAM_M_CLK_TWO, pio_en_q, b_sel_q, 1'h1);
    clk_three_used = f_used(`PAM_M_CLK_THREE, pio_en_q, b_sel_q, 1'h1);
    upper_b_used   = f_used(`PAM_M_DATA_UPPER, pio_en_q, b_sel_q, 1'h1);
    wide_bus = ((`PAM_M_DATA_UPPER & (pio_en_q | b_sel_q)) == `PAM_ALL_ZERO);
  end

  pam_pkg::pam_avail_t avail_d;

  always_comb begin
    avail_d.debug_serial_unit  = ~(wait_used | fast_irq_used);
    avail_d.timer_io           = ~wide_bus;
    avail_d.serial_port_one    = ~wide_bus;
    avail_d.clock_out_two      = ~wide_bus;
    avail_d.clock_out_three    = ~wide_bus;
    avail_d.chip_select_three  = ~nand_used;
    avail_d.serial_port_zero   = ~(nand_used | card_used);
    avail_d.chip_select_six    = ~spi_used;
    avail_d.chip_select_seven  = ~spi_used;
    avail_d.converter_trigger  = ~spi_used;
    avail_d.spi_select_zero    = ~irq_zero_used;
    avail_d.spi_select_one     = ~irq_one_used;
    avail_d.upper_address_bits = ~clk_low_used;
    avail_d.full_data_bus      = ~(clk_two_used | clk_three_used |
                                   upper_b_used);
    avail_d.gpio_on_wait_line  = pio_en_q[`PAM_WAIT_LINE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral-facing inputs and status.

  logic [31:0] a_in_d;
  logic [31:0] b_in_d;

  // Deselected peripheral A and B inputs idle high, as the pull-up would hold an open line.
  always_comb begin
    a_in_d = pad_in | pio_en_q | b_sel_q;
    b_in_d = pad_in | pio_en_q | ~b_sel_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gpio_in                  <= `PAM_ALL_ONES;
      periph_a_in              <= `PAM_ALL_ONES;
      periph_b_in              <= `PAM_ALL_ONES;
      peripheral_select_status <= RESET_PERIPH_MASK;
      avail                    <= '1;
    end else begin
      gpio_in                  <= pad_in;
      periph_a_in              <= a_in_d;
      periph_b_in              <= b_in_d;
      peripheral_select_status <= ~pio_en_d;
      avail                    <= avail_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line cells.

  // only this port is muxed here
  for (genvar i = 0; i < `PAM_LINES; i++) begin : g_line
    pam_pkg::pam_func_t fn;
    assign fn = pio_en_q[i] ? pam_pkg::PAM_FN_GPIO :
                (b_sel_q[i] ? pam_pkg::PAM_FN_B : pam_pkg::PAM_FN_A);
    pam_line_cell u_cell (
      .clock        (clock),
      .rst          (rst),
      .func         (fn),
      .pu_dis       (pu_dis_q[i]),
      .gpio_out     (gpio_out[i]),
      .gpio_oe      (gpio_oe[i]),
      .a_out        (periph_a_out[i]),
      .a_oe         (periph_a_oe[i]),
      .b_out        (periph_b_out[i]),
      .b_oe         (periph_b_oe[i]),
      .pad_out_q    (pad_out[i]),
      .pad_oe_n_q   (pad_oe_n[i]),
      .pad_pullup_q (pad_pullup[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_status_track: assert property (
    @(posedge clock) disable iff (rst)
    cfg_we |=> peripheral_select_status == ~$past(cfg.pio_en))
    else $error("select status does not follow the write");

  // line 29 data bit on A
  chk_line29_a: assert property (
    @(posedge clock) disable iff (rst)
    (!pio_en_q[29] && !b_sel_q[29] && periph_a_oe[29]) |=>
      (!pad_oe_n[29] && pad_out[29] == $past(periph_a_out[29])))
    else $error("line 29 does not carry function A");

  chk_line30_b: assert property (
    @(posedge clock) disable iff (rst)
    (!pio_en_q[30] && b_sel_q[30] && periph_b_oe[30]) |=>
      (!pad_oe_n[30] && pad_out[30] == $past(periph_b_out[30])))
    else $error("line 30 does not carry function B");

  chk_line31_b: assert property (
    @(posedge clock) disable iff (rst)
    (!pio_en_q[31] && b_sel_q[31] && periph_b_oe[31]) |=>
      (!pad_oe_n[31] && pad_out[31] == $past(periph_b_out[31])))
    else $error("line 31 does not carry function B");

  chk_wait_release: assert property (
    @(posedge clock) disable iff (rst)
    (cfg_we && cfg.pio_en[`PAM_WAIT_LINE]) |=> ##1
      avail.gpio_on_wait_line)
    else $error("wait line not released to general I/O");

  chk_wait_line_io: assert property (
    @(posedge clock) disable iff (rst)
    (pio_en_q[`PAM_WAIT_LINE] && gpio_oe[`PAM_WAIT_LINE]) |=>
      (!pad_oe_n[`PAM_WAIT_LINE] &&
       pad_out[`PAM_WAIT_LINE] == $past(gpio_out[`PAM_WAIT_LINE])))
    else $error("wait line does not carry general I/O");

  chk_wait_debug: assert property (
    @(posedge clock) disable iff (rst)
    wait_used |=> !avail.debug_serial_unit)
    else $error("debug unit shown free while wait in use");

  chk_debug_free: assert property (
    @(posedge clock) disable iff (rst)
    !(wait_used || fast_irq_used) |=> avail.debug_serial_unit)
    else $error("debug unit shown busy with its lines free");

  chk_wide_bus: assert property (
    @(posedge clock) disable iff (rst)
    wide_bus |=> !(avail.timer_io | avail.serial_port_one |
                   avail.clock_out_two | avail.clock_out_three))
    else $error("wide bus leaves a shared function free");

  chk_nand_excl: assert property (
    @(posedge clock) disable iff (rst)
    nand_used |=> !avail.chip_select_three && !avail.serial_port_zero)
    else $error("NAND use leaves shared functions free");

  chk_card_excl: assert property (
    @(posedge clock) disable iff (rst)
    card_used |=> !avail.serial_port_zero)
    else $error("flash card use leaves serial zero free");

  chk_spi_excl: assert property (
    @(posedge clock) disable iff (rst)
    spi_used |=> !(avail.chip_select_six | avail.chip_select_seven |
                   avail.converter_trigger))
    else $error("SPI use leaves shared functions free");

  chk_clock_out: assert property (
    @(posedge clock) disable iff (rst)
    (clk_low_used || clk_two_used) |=>
      (!avail.upper_address_bits || !avail.full_data_bus))
    else $error("clock output leaves bus bits free");

  chk_clock_data: assert property (
    @(posedge clock) disable iff (rst)
    (clk_two_used || clk_three_used) |=> !avail.full_data_bus)
    else $error("clock output two or three leaves data bus free");

  chk_fast_irq_debug: assert property (
    @(posedge clock) disable iff (rst)
    fast_irq_used |=> !avail.debug_serial_unit)
    else $error("debug unit shown free while fast irq used");

  chk_irq_zero_excl: assert property (
    @(posedge clock) disable iff (rst)
    irq_zero_used |=> !avail.spi_select_zero)
    else $error("SPI select zero shown free");

  chk_irq_one_excl: assert property (
    @(posedge clock) disable iff (rst)
    irq_one_used |=> !avail.spi_select_one)
    else $error("SPI select one shown free");

endmodule : pam_port_a_mux
`default_nettype wire

//--- logic/pam_consts.svh
// Line masks, reset values and sizes for the port A function multiplexer.
`ifndef PAM_CONSTS_SVH
`define PAM_CONSTS_SVH

`define PAM_LINES           32
`define PAM_RESET_PERIPH    32'h00000000
`define PAM_ALL_ONES        32'hFFFFFFFF
`define PAM_ALL_ZERO        32'h00000000
`define PAM_PIN_IDLE        1'h1
`define PAM_WAIT_LINE       1

`define PAM_M_FAST_IRQ      32'h00000001
`define PAM_M_EXT_WAIT      32'h00000002
`define PAM_M_SERIAL_ZERO   32'h0000007C
`define PAM_M_NAND          32'h00000060
`define PAM_M_FLASH_CARD    32'h0000301C
`define PAM_M_SPI           32'h00003F80
`define PAM_M_IRQ_ZERO      32'h00000400
`define PAM_M_IRQ_ONE       32'h00000800
`define PAM_M_CLK_LOW       32'h0000C000
`define PAM_M_CLK_TWO       32'h00010000
`define PAM_M_CLK_THREE     32'h00020000
`define PAM_M_DATA_UPPER    32'hFFFF0000
`define PAM_M_SERIAL_ONE    32'h007C0000
`define PAM_M_TIMER         32'hFF800000
`define PAM_M_LINES_29_31   32'hE0000000

`endif

//--- logic/pam_pkg.sv
// Types shared by the port A function multiplexer.
`default_nettype none
package pam_pkg;

  typedef enum logic [1:0] {
    PAM_FN_GPIO,
    PAM_FN_A,
    PAM_FN_B
  } pam_func_t;

  typedef struct packed {
    logic [31:0] pio_en;
    logic [31:0] b_sel;
    logic [31:0] pu_dis;
  } pam_cfg_t;

  typedef struct packed {
    logic debug_serial_unit;
    logic timer_io;
    logic serial_port_one;
    logic clock_out_two;
    logic clock_out_three;
    logic chip_select_three;
    logic serial_port_zero;
    logic chip_select_six;
    logic chip_select_seven;
    logic converter_trigger;
    logic spi_select_zero;
    logic spi_select_one;
    logic upper_address_bits;
    logic full_data_bus;
    logic gpio_on_wait_line;
  } pam_avail_t;

endpackage : pam_pkg
`default_nettype wire

//--- logic/pam_line_cell.sv
// One shared line: picks the driver of the pad and registers it.
`timescale 1ns/1ps
`default_nettype none
`include "pam_consts.svh"
module pam_line_cell (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire pam_pkg::pam_func_t func,
  input  wire logic              pu_dis,
  input  wire logic              gpio_out,
  input  wire logic              gpio_oe,
  input  wire logic              a_out,
  input  wire logic              a_oe,
  input  wire logic              b_out,
  input  wire logic              b_oe,
  output logic                   pad_out_q,
  output logic                   pad_oe_n_q,
  output logic                   pad_pullup_q
);

  logic pad_out_d;
  logic pad_oe_n_d;

  always_comb begin
    pad_out_d  = 1'h0;
    pad_oe_n_d = 1'h1;
    unique case (func)
      pam_pkg::PAM_FN_GPIO: begin
        pad_out_d  = gpio_out;
        pad_oe_n_d = ~gpio_oe;
      end
      pam_pkg::PAM_FN_A: begin
        pad_out_d  = a_out;
        pad_oe_n_d = ~a_oe;
      end
      pam_pkg::PAM_FN_B: begin
        pad_out_d  = b_out;
        pad_oe_n_d = ~b_oe;
      end
      default: begin
        pad_out_d  = 1'h0;
        pad_oe_n_d = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pad_out_q    <= 1'h0;
      pad_oe_n_q   <= 1'h1;
      pad_pullup_q <= 1'h1;
    end else begin
      pad_out_q    <= pad_out_d;
      pad_oe_n_q   <= pad_oe_n_d;
      pad_pullup_q <= ~pu_dis;
    end
  end

endmodule : pam_line_cell
`default_nettype wire

//--- testbench/pam_pad_model.sv
// Pad, pull-up and outside-driver model for the shared port A lines.
`timescale 1ns/1ps
`default_nettype none
module pam_pad_model (
  input  wire logic        clock,
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe_n,
  input  wire logic [31:0] pad_pullup,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic [31:0]      pad_in
);
  logic [31:0] float_q = 32'h5A5A5A5A;

  // A released line with no outside driver and no pull-up holds no level, so it toggles.
  always @(posedge clock) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup[i])
        pad_in[i] = 1'h1;
      else
        pad_in[i] = float_q[i];
    end
  end
endmodule : pam_pad_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the port A function multiplexer.
`timescale 1ns/1ps
`default_nettype none
`include "pam_consts.svh"
module tb_top;
  logic                clock = 1'h0;
  logic                rst;
  logic                cfg_we;
  pam_pkg::pam_cfg_t   cfg;
  logic [31:0]         gpio_out, gpio_oe, pa_out, pa_oe, pb_out, pb_oe;
  logic [31:0]         ext_en, ext_val, pad_in, pad_out, pad_oe_n;
  logic [31:0]         pad_pullup, gpio_in, pa_in, pb_in, status;
  pam_pkg::pam_avail_t avail;
  int                  miscompares = 0;
  int                  compares = 0;
  logic [31:0]         t_per [10] = '{32'h00000001, 32'h00000002,
    32'hFFFF0000, 32'h00000060, 32'h0000301C, 32'h00003F80,
    32'h00000400, 32'h00000800, 32'h00004000, 32'h00010000};
  logic [31:0]         t_b [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h00003F80, 32'h0, 32'h0, 32'h00004000, 32'h00010000};
  logic [31:0]         t_av [10] = '{32'h3FFF, 32'h3FFE, 32'h43FF,
    32'h7CFF, 32'h7EFF, 32'h7F1F, 32'h7FEF, 32'h7FF7,
    32'h7FFB, 32'h7FFD};

  always #20 clock = ~clock;

  pam_port_a_mux uut (
    .clock(clock), .rst(rst), .cfg_we(cfg_we), .cfg(cfg),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .periph_a_out(pa_out), .periph_a_oe(pa_oe),
    .periph_b_out(pb_out), .periph_b_oe(pb_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
    .gpio_in(gpio_in), .periph_a_in(pa_in), .periph_b_in(pb_in),
    .peripheral_select_status(status), .avail(avail)
  );

  pam_pad_model pads (
    .clock(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Reset is driven off the edge and released after six cycles.
  task automatic reset_and_check;
    @(posedge clock);
    #1 rst = 1'h1;
    repeat (6) @(posedge clock);
    #1 rst = 1'h0;
    @(posedge clock);
    #1;
    check("pad_oe_n", pad_oe_n, `PAM_ALL_ONES);
    check("pad_pullup", pad_pullup, `PAM_ALL_ONES);
    check("status", status, `PAM_RESET_PERIPH);
    check("avail", {17'h0, avail}, 32'h00007FFF);
  endtask : reset_and_check

  task automatic write_cfg(input logic [31:0] pio, input logic [31:0] bs,
                           input logic [31:0] pud);
    cfg_we = 1'h1;
    cfg = '{pio_en: pio, b_sel: bs, pu_dis: pud};
    @(posedge clock);
    #1 cfg_we = 1'h0;
    @(posedge clock);
    #1 check("status", status, ~pio);
    @(posedge clock);
    #1;
  endtask : write_cfg

  initial begin
    #(40 * 3000);
    miscompares++;
    stop_test();
  end

  initial begin
    rst = 1'h1;
    cfg_we = 1'h0;
    cfg = '0;
    {gpio_out, gpio_oe, pa_out, pa_oe, pb_out, pb_oe} = '0;
    {ext_en, ext_val} = '0;
    reset_and_check();
    $display("Test reset done");
    for (int i = 0; i < 10; i++) begin
      write_cfg(~t_per[i], t_b[i], 32'h0);
      check("avail", {17'h0, avail}, t_av[i]);
    end
    $display("Test conflicts done");
    write_cfg(32'h1FFFFFFF, 32'hC0000000, 32'h20000000);
    gpio_out = 32'h80000002;
    pa_out = 32'h20000000;
    pb_out = 32'hC0000000;
    {gpio_oe, pa_oe, pb_oe} = {96{1'h1}};
    @(posedge clock);
    #1 check("pad_out", pad_out, 32'hE0000002);
    check("pad_oe_n", pad_oe_n, 32'h0);
    check("pad_pullup", pad_pullup, 32'hDFFFFFFF);
    gpio_oe = 32'h7FFFFFFF;
    pa_oe = 32'hDFFFFFFF;
    pb_oe = 32'h3FFFFFFF;
    ext_en = 32'h60000000;
    @(posedge clock);
    #1 check("pad_oe_n", pad_oe_n, 32'hE0000000);
    @(posedge clock);
    #1 check("gpio_in", gpio_in, 32'h80000002);
    check("periph_a_in", pa_in, 32'hDFFFFFFF);
    check("periph_b_in", pb_in, 32'hBFFFFFFF);
    $display("Test pad path done");
    {gpio_oe, pa_oe, pb_oe} = '0;
    ext_en = '0;
    reset_and_check();
    $display("Test second reset done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
